/* File: hdl/port_io_regs.vh */
// port i/o special function register map, field layout and reset values
// assumes: included by the port i/o design files, definitions only
`ifndef PORT_IO_REGS_VH
`define PORT_IO_REGS_VH

// ----------------------------------------------------------------------
// port data registers (bit addressable except the fifth port)
// ----------------------------------------------------------------------
`define ADDR_FIRST_PORT_DATA   8'h80
`define ADDR_SECOND_PORT_DATA  8'h90
`define ADDR_THIRD_PORT_DATA   8'hA0
`define ADDR_FOURTH_PORT_DATA  8'hB0
`define ADDR_FIFTH_PORT_DATA   8'hB5

// ----------------------------------------------------------------------
// per-pin configuration registers
// ----------------------------------------------------------------------
`define ADDR_SKIP_MASK_0       8'hD4
`define ADDR_SKIP_MASK_1       8'hD5
`define ADDR_SKIP_MASK_2       8'hD6
`define ADDR_SKIP_MASK_3       8'hD7
`define ADDR_INPUT_MODE_0      8'hF1
`define ADDR_INPUT_MODE_1      8'hF2
`define ADDR_INPUT_MODE_2      8'hF3
`define ADDR_INPUT_MODE_3      8'hF4
`define ADDR_OUTPUT_DRIVE_0    8'hA4
`define ADDR_OUTPUT_DRIVE_1    8'hA5
`define ADDR_OUTPUT_DRIVE_2    8'hA6
`define ADDR_OUTPUT_DRIVE_3    8'hA7
`define ADDR_OUTPUT_DRIVE_4    8'hA8

// ----------------------------------------------------------------------
// reset values and field layout
// ----------------------------------------------------------------------
`define RST_PORT_DATA          8'hFF
`define RST_SKIP_MASK          8'h00
`define RST_INPUT_MODE         8'hFF
`define RST_OUTPUT_DRIVE       8'h00
`define BIT_BASE_MASK          8'hF8
`define BIT_INDEX_LSB          0
`define BIT_INDEX_MSB          2
`define NO_PORT                3'h7
`define UNMAPPED_READ          8'h00

`endif

/* File: hdl/pin_sync.v */
// two-flop synchroniser for a bus of unrelated pin levels
// assumes: each bit is an independent level, no word coherence needed
`timescale 1ns/1ps

module pin_sync #(
    parameter W = 40
) (
    input  wire         clk_sys,
    input  wire         rst_n,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

    reg [W-1:0] stage1;

    // first stage feeds only the second stage
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            stage1   <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

/* File: hdl/port_drive.v */
// output driver control for one port of pins
// assumes: crossbar select and peripheral data come from the same clock
`timescale 1ns/1ps

module port_drive #(
    parameter W = 8
) (
    input  wire         clk_sys,
    input  wire         rst_n,
    input  wire [W-1:0] latch,
    input  wire [W-1:0] periph_sel,
    input  wire [W-1:0] periph_out,
    input  wire [W-1:0] push_pull,
    input  wire [W-1:0] digital,
    input  wire [W-1:0] force_od,
    output reg  [W-1:0] pin_out,
    output reg  [W-1:0] pin_oe
);

    reg [W-1:0] level;
    reg [W-1:0] pp_eff;

    // crossbar output wins over the latch; smbus pins never push high
    always @* begin
        level  = (periph_sel & periph_out) | (~periph_sel & latch);
        pp_eff = push_pull & ~force_od;
    end

    // open drain pulls low only; analog cells keep the driver off
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_out <= {W{1'b0}};
            pin_oe  <= {W{1'b0}};
        end else begin
            pin_out <= level & pp_eff & digital;
            pin_oe  <= (pp_eff | ~level) & digital;
        end
    end

endmodule

/* File: hdl/port_io_latch_and_mode_control.v */
// port latches, pin readback and per-pin mode registers for five ports
// assumes: cpu presents sfr byte and bit accesses on clk_sys, one-cycle
// strobes, and raises sfr_rmw during the read half of a read-modify-write
`timescale 1ns/1ps
`include "port_io_regs.vh"

module port_io_latch_and_mode_control #(
    parameter NPORT = 5,
    parameter W     = 8
) (
    input  wire                 clk_sys,
    input  wire                 rst_n,
    input  wire [7:0]           sfr_addr,
    input  wire                 sfr_wr,
    input  wire                 sfr_rd,
    input  wire                 sfr_rmw,
    input  wire [7:0]           sfr_wdata,
    output reg  [7:0]           sfr_rdata,
    input  wire [7:0]           sfr_bit_addr,
    input  wire                 sfr_bit_wr,
    input  wire                 sfr_bit_rd,
    input  wire                 sfr_bit_wdata,
    output reg                  sfr_bit_rdata,
    input  wire [NPORT*W-1:0]   pin_in,
    output wire [NPORT*W-1:0]   pin_out,
    output wire [NPORT*W-1:0]   pin_oe,
    input  wire [NPORT*W-1:0]   periph_sel,
    input  wire [NPORT*W-1:0]   periph_out,
    input  wire [NPORT*W-1:0]   smbus_pin,
    output wire [4*W-1:0]       crossbar_skip_mask,
    output wire [4*W-1:0]       input_mode_select,
    output wire [NPORT*W-1:0]   output_drive_select
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    localparam NB = NPORT * W;

    // ------------------------------------------------------------------
    // address map and usage notes
    // ------------------------------------------------------------------
    // port data bytes:   0x80, 0x90, 0xA0, 0xB0, fifth port at 0xB5
    // skip masks:        0xD4 to 0xD7, ports zero to three only
    // input mode:        0xF1 to 0xF4, 1 = digital, 0 = analog
    // output drive:      0xA4 to 0xA8, 1 = push-pull, 0 = open drain
    // every register is seen on every page; paging lives in the core
    //
    // read paths
    //   plain byte or bit read returns synchronised pin levels, so a
    //   value driven on a pad shows up two clocks after it settles
    //   rmw read returns the latch, so a pad held low by the board
    //   cannot leak into a set or clear of a neighbouring bit
    //   analog cells read zero; their digital input buffer is off
    //
    // write paths
    //   byte writes replace a whole latch or mode byte
    //   bit writes touch one latch bit only, never a mode register
    //   byte and bit write to one latch in one cycle: the bit wins
    //   for its own bit, the byte fills the rest
    //   unmapped addresses are ignored on write and read as zero
    //
    // pad drive
    //   pads are registered one clock after the latch or mode change,
    //   which keeps glitches from the crossbar select mux off the board
    //   open drain only ever pulls low; a released pad floats to its
    //   board pull-up, which the readback then sees
    //   smbus pins stay open drain whatever the drive byte says
    //   analog cells keep the driver off in either drive mode
    //
    // reset
    //   latches reset high so open drain pads come up released
    //   drive bytes reset to open drain, input modes to digital
    //   read data registers reset to zero until the first read
    //   pin synchronisers clear too, so early reads return zero
    //
    // limitations
    //   the skip masks are storage only; the crossbar that honours
    //   them sits outside this block and reports through periph_sel
    //   opcode decode is not done here; the core flags rmw reads
    //   a reset in mid-instruction loses the pending rmw write-back
    //   no interrupt or wake logic lives in this block

    reg  [NB-1:0]  latch;
    reg  [4*W-1:0] skip;
    reg  [4*W-1:0] mdin;
    reg  [NB-1:0]  mdout;
    wire [NB-1:0]  pin_sync_lvl;
    wire [NB-1:0]  digital;
    wire [NB-1:0]  pin_read;

    reg  [2:0]     bit_port;
    reg  [5:0]     bit_idx;
    reg  [7:0]     next_rdata;
    reg            next_bit_rdata;

    // ------------------------------------------------------------------
    // pin input synchronisers
    // ------------------------------------------------------------------
    // pins are asynchronous to clk_sys, so nothing reads them unsynced
    pin_sync #(
        .W (NB)
    ) u_pin_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in (pin_in),
        .sync_out (pin_sync_lvl)
    );

    // ------------------------------------------------------------------
    // input mode and pin readback
    // ------------------------------------------------------------------
    // input mode select
    assign digital = {{(NB-4*W){1'b1}}, mdin};

    // analog cells read low
    // analog cells have the digital buffer off; zero keeps reads defined
    assign pin_read = pin_sync_lvl & digital;

    assign crossbar_skip_mask  = skip;
    assign input_mode_select   = mdin;
    assign output_drive_select = mdout;

    // ------------------------------------------------------------------
    // bit address decode
    // ------------------------------------------------------------------
    // bit addressable ports
    // only bases ending in zero are bit addressable; the fifth port sits
    // at a base that is not, so a bit access can never reach it
    always @* begin
        case (sfr_bit_addr & `BIT_BASE_MASK)
            `ADDR_FIRST_PORT_DATA:  bit_port = 3'h0;
            `ADDR_SECOND_PORT_DATA: bit_port = 3'h1;
            `ADDR_THIRD_PORT_DATA:  bit_port = 3'h2;
            `ADDR_FOURTH_PORT_DATA: bit_port = 3'h3;
            default:                bit_port = `NO_PORT;
        endcase
        bit_idx = {bit_port, sfr_bit_addr[`BIT_INDEX_MSB:`BIT_INDEX_LSB]};
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // latch on write
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            latch <= {NPORT{`RST_PORT_DATA}};
            skip  <= {4{`RST_SKIP_MASK}};
            mdin  <= {4{`RST_INPUT_MODE}};
            mdout <= {NPORT{`RST_OUTPUT_DRIVE}};
        end else begin
            if (sfr_wr) begin
                case (sfr_addr)
                    `ADDR_FIRST_PORT_DATA:  latch[7:0]   <= sfr_wdata;
                    `ADDR_SECOND_PORT_DATA: latch[15:8]  <= sfr_wdata;
                    `ADDR_THIRD_PORT_DATA:  latch[23:16] <= sfr_wdata;
                    `ADDR_FOURTH_PORT_DATA: latch[31:24] <= sfr_wdata;
                    `ADDR_FIFTH_PORT_DATA:  latch[39:32] <= sfr_wdata;
                    `ADDR_SKIP_MASK_0:      skip[7:0]    <= sfr_wdata;
                    `ADDR_SKIP_MASK_1:      skip[15:8]   <= sfr_wdata;
                    `ADDR_SKIP_MASK_2:      skip[23:16]  <= sfr_wdata;
                    `ADDR_SKIP_MASK_3:      skip[31:24]  <= sfr_wdata;
                    `ADDR_INPUT_MODE_0:     mdin[7:0]    <= sfr_wdata;
                    `ADDR_INPUT_MODE_1:     mdin[15:8]   <= sfr_wdata;
                    `ADDR_INPUT_MODE_2:     mdin[23:16]  <= sfr_wdata;
                    `ADDR_INPUT_MODE_3:     mdin[31:24]  <= sfr_wdata;
                    `ADDR_OUTPUT_DRIVE_0:   mdout[7:0]   <= sfr_wdata;
                    `ADDR_OUTPUT_DRIVE_1:   mdout[15:8]  <= sfr_wdata;
                    `ADDR_OUTPUT_DRIVE_2:   mdout[23:16] <= sfr_wdata;
                    `ADDR_OUTPUT_DRIVE_3:   mdout[31:24] <= sfr_wdata;
                    `ADDR_OUTPUT_DRIVE_4:   mdout[39:32] <= sfr_wdata;
                    default: ;
                endcase
            end
            // bit destination is rmw
            // a bit write touches one latch bit, its neighbours stay as
            // latched rather than picking up pin levels
            if (sfr_bit_wr && (bit_port != `NO_PORT)) begin
                latch[bit_idx] <= sfr_bit_wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // byte read mux
    // ------------------------------------------------------------------
    // plain reads see pins
    // rmw flag from core
    // the core decodes the opcode; this block only honours sfr_rmw
    always @* begin
        next_rdata = `UNMAPPED_READ;
        case (sfr_addr)
            `ADDR_FIRST_PORT_DATA:
                next_rdata = sfr_rmw ? latch[7:0]   : pin_read[7:0];
            `ADDR_SECOND_PORT_DATA:
                next_rdata = sfr_rmw ? latch[15:8]  : pin_read[15:8];
            `ADDR_THIRD_PORT_DATA:
                next_rdata = sfr_rmw ? latch[23:16] : pin_read[23:16];
            `ADDR_FOURTH_PORT_DATA:
                next_rdata = sfr_rmw ? latch[31:24] : pin_read[31:24];
            `ADDR_FIFTH_PORT_DATA:
                next_rdata = sfr_rmw ? latch[39:32] : pin_read[39:32];
            `ADDR_SKIP_MASK_0:    next_rdata = skip[7:0];
            `ADDR_SKIP_MASK_1:    next_rdata = skip[15:8];
            `ADDR_SKIP_MASK_2:    next_rdata = skip[23:16];
            `ADDR_SKIP_MASK_3:    next_rdata = skip[31:24];
            `ADDR_INPUT_MODE_0:   next_rdata = mdin[7:0];
            `ADDR_INPUT_MODE_1:   next_rdata = mdin[15:8];
            `ADDR_INPUT_MODE_2:   next_rdata = mdin[23:16];
            `ADDR_INPUT_MODE_3:   next_rdata = mdin[31:24];
            `ADDR_OUTPUT_DRIVE_0: next_rdata = mdout[7:0];
            `ADDR_OUTPUT_DRIVE_1: next_rdata = mdout[15:8];
            `ADDR_OUTPUT_DRIVE_2: next_rdata = mdout[23:16];
            `ADDR_OUTPUT_DRIVE_3: next_rdata = mdout[31:24];
            `ADDR_OUTPUT_DRIVE_4: next_rdata = mdout[39:32];
            default:              next_rdata = `UNMAPPED_READ;
        endcase
    end

    // ------------------------------------------------------------------
    // bit read mux
    // ------------------------------------------------------------------
    // rmw bit reads latch
    // jbc and friends must not pick up a pin held by the board
    always @* begin
        next_bit_rdata = 1'b0;
        if (bit_port != `NO_PORT) begin
            next_bit_rdata = sfr_rmw ? latch[bit_idx] : pin_read[bit_idx];
        end
    end

    // ------------------------------------------------------------------
    // registered read data
    // ------------------------------------------------------------------
    // read data is held until the next read so the core may sample late
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sfr_rdata     <= 8'h00;
            sfr_bit_rdata <= 1'b0;
        end else begin
            if (sfr_rd) begin
                sfr_rdata <= next_rdata;
            end
            if (sfr_bit_rd) begin
                sfr_bit_rdata <= next_bit_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // output drivers
    // ------------------------------------------------------------------
    // drive mode per pin
    genvar gp;
    generate
        for (gp = 0; gp < NPORT; gp = gp + 1) begin : g_port
            port_drive #(
                .W (W)
            ) u_drive (
                .clk_sys    (clk_sys),
                .rst_n      (rst_n),
                .latch      (latch[gp*W +: W]),
                .periph_sel (periph_sel[gp*W +: W]),
                .periph_out (periph_out[gp*W +: W]),
                .push_pull  (mdout[gp*W +: W]),
                .digital    (digital[gp*W +: W]),
                .force_od   (smbus_pin[gp*W +: W]),
                .pin_out    (pin_out[gp*W +: W]),
                .pin_oe     (pin_oe[gp*W +: W])
            );
        end
    endgenerate

endmodule

/* File: verification/board_pins.sv */
// board side of the port pads: pull-ups plus optional pull-downs
// assumes: pin_oe high means the port cell drives pin_out on the pad
`timescale 1ns/1ps

module board_pins #(
    parameter N = 40
) (
    input  wire [N-1:0] pin_out,
    input  wire [N-1:0] pin_oe,
    input  wire [N-1:0] pull_low,
    output wire [N-1:0] pin_in
);
    // released pads go to the pull-up unless the board grounds them
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~pull_low);
endmodule

/* File: verification/port_io_properties.sv */
// timing checks on the port latch, readback and pad drive
// assumes: bound to the port i/o top, single clk_sys domain
`timescale 1ns/1ps

module port_io_properties #(
    parameter NPORT = 5,
    parameter W     = 8
) (
    input wire               clk_sys,
    input wire               rst_n,
    input wire [7:0]         sfr_addr,
    input wire               sfr_wr,
    input wire               sfr_rd,
    input wire               sfr_rmw,
    input wire [7:0]         sfr_wdata,
    input wire [7:0]         sfr_rdata,
    input wire [7:0]         sfr_bit_addr,
    input wire               sfr_bit_wr,
    input wire               sfr_bit_wdata,
    input wire [NPORT*W-1:0] pin_out,
    input wire [NPORT*W-1:0] pin_oe,
    input wire [NPORT*W-1:0] periph_sel,
    input wire [NPORT*W-1:0] smbus_pin,
    input wire [4*W-1:0]     crossbar_skip_mask,
    input wire [4*W-1:0]     input_mode_select,
    input wire [NPORT*W-1:0] output_drive_select
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_latch_drive: assert property (
        sfr_wr && sfr_addr == 8'h80 ##1 (!sfr_wr && !sfr_bit_wr
        && output_drive_select[7:0] == 8'hFF && smbus_pin[7:0] == 8'h00
        && input_mode_select[7:0] == 8'hFF && periph_sel[7:0] == 8'h00)
        |=> pin_out[7:0] == $past(sfr_wdata, 2) && pin_oe[7:0] == 8'hFF)
        else $error("latch byte not on pads");
    chk_rmw_latch: assert property (
        sfr_wr && sfr_addr == 8'h80 ##1 (!sfr_wr && !sfr_bit_wr)
        ##1 (sfr_rd && sfr_rmw && sfr_addr == 8'h80)
        |=> sfr_rdata == $past(sfr_wdata, 3))
        else $error("rmw read not the latch");
    chk_bit_write: assert property (
        sfr_bit_wr && sfr_bit_addr[7:3] == 5'h10
        ##1 (!sfr_wr && !sfr_bit_wr)
        ##1 (sfr_rd && sfr_rmw && sfr_addr == 8'h80)
        |=> sfr_rdata[$past(sfr_bit_addr[2:0], 3)]
            == $past(sfr_bit_wdata, 3))
        else $error("bit write lost");
    chk_smbus_od: assert property (
        (pin_out & $past(smbus_pin)) == 0)
        else $error("smbus pad driven high");
    chk_od_no_high: assert property (
        (pin_out & ~$past(output_drive_select)) == 0)
        else $error("open drain pad driven high");
    chk_analog_off: assert property (
        (pin_oe[4*W-1:0] & ~$past(input_mode_select)) == 0)
        else $error("analog pad driven");
    chk_skip_store: assert property (
        sfr_wr && sfr_addr == 8'hD4
        |=> crossbar_skip_mask[7:0] == $past(sfr_wdata))
        else $error("skip mask not stored");
    chk_fifth_drive: assert property (
        output_drive_select[39:32] == 8'hFF && smbus_pin[39:32] == 8'h00
        && periph_sel[39:32] == 8'h00 && pin_out[39:32] == 8'hFF
        |=> pin_oe[39:32] == 8'hFF)
        else $error("fifth port not digital");
endmodule

bind port_io_latch_and_mode_control port_io_properties #(
    .NPORT(NPORT),
    .W(W)
) u_chk (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_rmw(sfr_rmw),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .sfr_bit_addr(sfr_bit_addr),
    .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_wdata(sfr_bit_wdata),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .periph_sel(periph_sel),
    .smbus_pin(smbus_pin),
    .crossbar_skip_mask(crossbar_skip_mask),
    .input_mode_select(input_mode_select),
    .output_drive_select(output_drive_select)
);

/* File: verification/tb_port_io_latch_and_mode_control.sv */
// self-checking bench: sfr byte and bit cycles against the port block
// assumes: board_pins closes the pad loop, checker is bound in
`timescale 1ns/1ps
`include "port_io_regs.vh"

module tb_port_io_latch_and_mode_control;
    reg  [7:0]  sfr_addr, sfr_wdata, sfr_bit_addr;
    reg         clk_sys, rst_n, sfr_wr, sfr_rd, sfr_rmw;
    reg         sfr_bit_wr, sfr_bit_rd, sfr_bit_wdata;
    reg  [39:0] periph_sel, periph_out, smbus_pin, pull_low;
    wire [7:0]  sfr_rdata;
    wire        sfr_bit_rdata;
    wire [39:0] pin_in, pin_out, pin_oe, drive;
    wire [31:0] skip, imode;
    integer     num_errors, n_compared, i;

    port_io_latch_and_mode_control dut (.clk_sys(clk_sys),
        .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_bit_addr(sfr_bit_addr),
        .sfr_bit_wr(sfr_bit_wr), .sfr_bit_rd(sfr_bit_rd),
        .sfr_bit_wdata(sfr_bit_wdata), .sfr_bit_rdata(sfr_bit_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .periph_sel(periph_sel), .periph_out(periph_out),
        .smbus_pin(smbus_pin), .crossbar_skip_mask(skip),
        .input_mode_select(imode), .output_drive_select(drive));
    board_pins board (.pin_out(pin_out), .pin_oe(pin_oe),
        .pull_low(pull_low), .pin_in(pin_in));

    // compare and count; unknowns never match
    task chk(input [7:0] g, input [7:0] e);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("wrong value at %0t: got %h expected %h",
                         $time, g, e);
            end
        end
    endtask
    // strobes rise after one edge and fall after the taking edge
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            sfr_addr  <= a;
            sfr_wdata <= d;
            sfr_wr    <= 1'b1;
            @(posedge clk_sys);
            sfr_wr    <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input m, input [7:0] e);
        begin
            @(posedge clk_sys);
            sfr_addr <= a;
            sfr_rmw  <= m;
            sfr_rd   <= 1'b1;
            @(posedge clk_sys);
            sfr_rd   <= 1'b0;
            #1 chk(sfr_rdata, e);
        end
    endtask
    task bwr(input [7:0] a, input b);
        begin
            @(posedge clk_sys);
            sfr_bit_addr  <= a;
            sfr_bit_wdata <= b;
            sfr_bit_wr    <= 1'b1;
            @(posedge clk_sys);
            sfr_bit_wr    <= 1'b0;
        end
    endtask
    task brd(input [7:0] a, input m, input e);
        begin
            @(posedge clk_sys);
            sfr_bit_addr <= a;
            sfr_rmw      <= m;
            sfr_bit_rd   <= 1'b1;
            @(posedge clk_sys);
            sfr_bit_rd   <= 1'b0;
            #1 chk({7'h00, sfr_bit_rdata}, {7'h00, e});
        end
    endtask
    task conclude;
        begin
            $display("compared %0d, errors %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // hang guard, far beyond the roughly 150 cycles the tests need
    initial begin
        #100000;
        num_errors = num_errors + 1;
        conclude;
    end

    initial begin
        {sfr_addr, sfr_wdata, sfr_bit_addr} = 24'h000000;
        {rst_n, sfr_wr, sfr_rd, sfr_rmw} = 4'h0;
        {sfr_bit_wr, sfr_bit_rd, sfr_bit_wdata} = 3'h0;
        {periph_sel, periph_out, smbus_pin, pull_low} = 160'h0;
        num_errors = 0;
        n_compared = 0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            rd(8'h80 + {i[3:0], 4'h0}, 1'b1, `RST_PORT_DATA);
            rd(8'hD4 + i[7:0], 1'b0, `RST_SKIP_MASK);
            rd(8'hF1 + i[7:0], 1'b0, `RST_INPUT_MODE);
            rd(8'hA4 + i[7:0], 1'b0, `RST_OUTPUT_DRIVE);
            wr(8'hD4 + i[7:0], 8'h5A ^ i[7:0]);
            rd(8'hD4 + i[7:0], 1'b0, 8'h5A ^ i[7:0]);
        end
        // gpio use of port zero: software skips its pins first
        wr(`ADDR_SKIP_MASK_0, 8'hFF);
        #1 chk(skip[7:0], 8'hFF);
        rd(`ADDR_FIFTH_PORT_DATA, 1'b1, `RST_PORT_DATA);
        wr(8'hF5, 8'h00);
        rd(8'hF5, 1'b0, `UNMAPPED_READ);
        bwr(8'hA8, 1'b1);
        rd(`ADDR_OUTPUT_DRIVE_4, 1'b0, `RST_OUTPUT_DRIVE);
        wr(`ADDR_OUTPUT_DRIVE_4, 8'hFF);
        repeat (3) @(posedge clk_sys);
        #1 chk(pin_oe[39:32], 8'hFF);
        // push-pull latch write, latch then pads
        wr(`ADDR_OUTPUT_DRIVE_0, 8'hFF);
        wr(`ADDR_FIRST_PORT_DATA, 8'h5A);
        rd(`ADDR_FIRST_PORT_DATA, 1'b1, 8'h5A);
        repeat (4) @(posedge clk_sys);
        #1 chk(pin_out[7:0], 8'h5A);
        rd(`ADDR_FIRST_PORT_DATA, 1'b0, 8'h5A);
        // open drain with pin 0 grounded: pins and latch differ
        pull_low <= 40'h01;
        wr(`ADDR_OUTPUT_DRIVE_0, 8'h00);
        wr(`ADDR_FIRST_PORT_DATA, 8'h0F);
        repeat (4) @(posedge clk_sys);
        #1 chk(pin_oe[7:0], 8'hF0);
        rd(`ADDR_FIRST_PORT_DATA, 1'b0, 8'h0E);
        rd(`ADDR_FIRST_PORT_DATA, 1'b1, 8'h0F);
        bwr(8'h87, 1'b1);
        rd(`ADDR_FIRST_PORT_DATA, 1'b1, 8'h8F);
        brd(8'h80, 1'b0, 1'b0);
        brd(8'h80, 1'b1, 1'b1);
        // crossbar owns pin 1 and drives it low
        periph_sel <= 40'h02;
        repeat (4) @(posedge clk_sys);
        rd(`ADDR_FIRST_PORT_DATA, 1'b0, 8'h8C);
        // smbus pin 7 stays open drain under push-pull
        smbus_pin <= 40'h80;
        pull_low  <= 40'h00;
        wr(`ADDR_OUTPUT_DRIVE_0, 8'hFF);
        repeat (4) @(posedge clk_sys);
        #1 chk(pin_oe[7:0], 8'h7F);
        chk(drive[7:0], 8'hFF);
        rd(`ADDR_FIRST_PORT_DATA, 1'b0, 8'h8D);
        wr(`ADDR_INPUT_MODE_0, 8'hFE);
        repeat (4) @(posedge clk_sys);
        #1 chk(pin_oe[7:0], 8'h7E);
        chk(imode[7:0], 8'hFE);
        rd(`ADDR_FIRST_PORT_DATA, 1'b0, 8'h8C);
        // second reset in mid-run
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`ADDR_FIRST_PORT_DATA, 1'b1, `RST_PORT_DATA);
        rd(`ADDR_SKIP_MASK_0, 1'b0, `RST_SKIP_MASK);
        conclude;
    end
endmodule
